// ### src/tdm_monitor.sv
// Thermal throttle duty monitor: filtered active-time accumulator,
// period snapshot and single-assertion limit check.
// Assumes the peripheral bus and the 90 kHz strobe are on mclk.
`timescale 1ns/1ps
module tdm_monitor (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Slow tick and pin
  input wire logic slow_tick_enable,
  input wire logic thermal_throttle_n,
  // Peripheral bus
  input wire logic spb_rd,
  input wire logic spb_wr,
  input wire logic [7:0] spb_addr,
  input wire logic [3:0] spb_be,
  input wire logic [31:0] spb_wdata,
  output logic [31:0] spb_rdata,
  output logic spb_rvalid,
  // Service request
  output logic interrupt
);
  // ==========================================================
  // Helpers
  function automatic logic [31:0] tdm_merge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction : tdm_merge

  function automatic logic [31:0] tdm_hold_view(input logic [23:0] live, input logic [15:0] hold,
                                                input logic [3:0] be);
    if (be == tdm_pkg::BE_WORD || be[0]) begin
      return {8'h00, live};
    end
    return {8'h00, hold, live[7:0]};
  endfunction : tdm_hold_view

  // ==========================================================
  // State
  logic tt_s1_reg, tt_s2_reg;
  logic [5:0] run_reg;
  logic [23:0] active_reg, cum_reg, snap_reg, period_reg, per_cnt_reg;
  logic [15:0] hold_cum_reg, hold_snap_reg, acnt_reg, acnt_cap_reg, alim_reg;
  logic en_reg, asts_reg, psts_reg, aie_reg, pie_reg;
  logic low, step, filtered_active_valid, expire, period_wr, cum_clr, ctl_wr, lim_hit;
  logic [31:0] ctl_view, wd_period, wd_alim, rd_next;

  // Pin synchroniser, independent of pin mux
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      tt_s1_reg <= 1'b1;
      tt_s2_reg <= 1'b1;
    end else begin
      tt_s1_reg <= thermal_throttle_n;
      tt_s2_reg <= tt_s1_reg;
    end
  end

  // Decoded events
  assign low = ~tt_s2_reg;
  assign step = en_reg & slow_tick_enable & low;
  assign filtered_active_valid = low && (run_reg > tdm_pkg::FILT_TICKS);
  assign period_wr = spb_wr && spb_addr == tdm_pkg::OFF_PERIOD;
  assign ctl_wr = spb_wr && spb_addr == tdm_pkg::OFF_CTL && spb_be[0];
  assign expire = en_reg && slow_tick_enable && period_reg != tdm_pkg::CNT_RST
                  && per_cnt_reg == 24'h000001 && !period_wr;
  assign cum_clr = expire || period_wr;
  assign wd_period = tdm_merge({8'h00, period_reg}, spb_wdata, spb_be);
  assign wd_alim = tdm_merge({16'h0000, alim_reg}, spb_wdata, spb_be);
  assign lim_hit = step && acnt_reg != tdm_pkg::ACNT_MAX
                   && (acnt_reg + 16'h0001) >= alim_reg;

  // Run length of the present low period, saturating past the filter
  always_ff @(posedge mclk) begin
    if (!rstn || !low || !en_reg) begin
      run_reg <= 6'h00;
    end else if (step && run_reg <= tdm_pkg::FILT_TICKS) begin
      run_reg <= run_reg + 6'h01;
    end
  end

  // Active counter: clear, advance, or fall back after a short pulse
  always_ff @(posedge mclk) begin
    if (!rstn || !en_reg || cum_clr) begin
      active_reg <= tdm_pkg::CNT_RST;
    end else if (step) begin
      active_reg <= active_reg + 24'h000001;
    end else if (!low) begin
      active_reg <= cum_reg; // Discard a short run
    end
  end

  // Cumulative count follows only within a long enough run
  always_ff @(posedge mclk) begin
    if (!rstn || cum_clr) begin
      cum_reg <= tdm_pkg::CNT_RST;
    end else if (step && run_reg >= tdm_pkg::FILT_TICKS) begin
      cum_reg <= active_reg + 24'h000001;
    end
  end

  // Period counter and snapshot
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      period_reg <= tdm_pkg::CNT_RST;
      per_cnt_reg <= tdm_pkg::CNT_RST;
      snap_reg <= tdm_pkg::CNT_RST;
    end else begin
      if (period_wr) begin
        period_reg <= wd_period[23:0];
      end
      if (expire) begin
        snap_reg <= cum_reg;
      end
      if (!en_reg || period_reg == tdm_pkg::CNT_RST) begin
        per_cnt_reg <= tdm_pkg::CNT_RST;
      end else if (period_wr) begin
        per_cnt_reg <= wd_period[23:0];
      end else if (slow_tick_enable) begin
        per_cnt_reg <= (per_cnt_reg <= 24'h000001) ? period_reg
                       : per_cnt_reg - 24'h000001;
      end
    end
  end

  // Single-assertion counter and capture
  always_ff @(posedge mclk) begin
    if (!rstn || !low || !en_reg) begin
      acnt_reg <= tdm_pkg::ACNT_RST;
    end else if (step && acnt_reg != tdm_pkg::ACNT_MAX) begin
      acnt_reg <= acnt_reg + 16'h0001;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      acnt_cap_reg <= tdm_pkg::ACNT_RST;
      alim_reg <= tdm_pkg::ACNT_RST;
    end else begin
      if (lim_hit) begin
        acnt_cap_reg <= acnt_reg + 16'h0001;
      end
      if (spb_wr && spb_addr == tdm_pkg::OFF_ALIM) begin
        alim_reg <= wd_alim[15:0];
      end
    end
  end

  // Control and sticky status, set wins over clear
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      en_reg <= 1'b0;
      aie_reg <= 1'b0;
      pie_reg <= 1'b0;
      asts_reg <= 1'b0;
      psts_reg <= 1'b0;
    end else begin
      if (ctl_wr) begin
        en_reg <= spb_wdata[tdm_pkg::CTL_EN];
        aie_reg <= spb_wdata[tdm_pkg::CTL_AIE];
        pie_reg <= spb_wdata[tdm_pkg::CTL_PIE];
      end
      asts_reg <= lim_hit | (asts_reg & ~(ctl_wr & spb_wdata[tdm_pkg::CTL_ASTS]));
      psts_reg <= expire | (psts_reg & ~(ctl_wr & spb_wdata[tdm_pkg::CTL_PSTS]));
    end
  end

  assign interrupt = (asts_reg & aie_reg) | (psts_reg & pie_reg);
  assign ctl_view = {27'h0, pie_reg, aie_reg, psts_reg, asts_reg, en_reg};

  // Holding registers for partial reads of counts
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      hold_cum_reg <= tdm_pkg::ACNT_RST;
      hold_snap_reg <= tdm_pkg::ACNT_RST;
    end else if (spb_rd && spb_be[0]) begin
      if (spb_addr == tdm_pkg::OFF_CUM) begin
        hold_cum_reg <= filtered_active_valid ? active_reg[23:8] : cum_reg[23:8];
      end
      if (spb_addr == tdm_pkg::OFF_SNAP) begin
        hold_snap_reg <= snap_reg[23:8];
      end
    end
  end

  // Read multiplexer, unmapped reads return zero
  always_comb begin
    case (spb_addr)
      tdm_pkg::OFF_CUM: rd_next = tdm_hold_view(filtered_active_valid ? active_reg : cum_reg,
                                                hold_cum_reg, spb_be);
      tdm_pkg::OFF_SNAP: rd_next = tdm_hold_view(snap_reg, hold_snap_reg, spb_be);
      tdm_pkg::OFF_PERIOD: rd_next = {8'h00, period_reg};
      tdm_pkg::OFF_CTL: rd_next = ctl_view;
      tdm_pkg::OFF_ACNT: rd_next = {16'h0000, acnt_cap_reg};
      tdm_pkg::OFF_ALIM: rd_next = {16'h0000, alim_reg};
      default: rd_next = 32'h00000000;
    endcase
  end

  // Registered read answer
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      spb_rdata <= 32'h00000000;
      spb_rvalid <= 1'b0;
    end else begin
      spb_rvalid <= spb_rd;
      if (spb_rd) begin
        spb_rdata <= rd_next;
      end
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  property p_short_run;
    (!(step && run_reg >= tdm_pkg::FILT_TICKS) && !cum_clr) |=> $stable(cum_reg);
  endproperty
  a_short_run: assert property (p_short_run) else $error("cum moved outside run");

  property p_live_read;
    (spb_rd && spb_addr == tdm_pkg::OFF_CUM && spb_be == 4'hF && filtered_active_valid)
      |=> spb_rdata[23:0] == $past(active_reg);
  endproperty
  a_live_read: assert property (p_live_read) else $error("live read wrong");

  property p_reload;
    (en_reg && slow_tick_enable && per_cnt_reg == 24'h000001 && !period_wr
     && period_reg != 24'h000000) |=> per_cnt_reg == $past(period_reg);
  endproperty
  a_reload: assert property (p_reload) else $error("period not reloaded");

  property p_snap;
    expire |=> snap_reg == $past(cum_reg) && psts_reg;
  endproperty
  a_snap: assert property (p_snap) else $error("snapshot missed");

  property p_clear;
    expire |=> cum_reg == 24'h000000 && active_reg == 24'h000000;
  endproperty
  a_clear: assert property (p_clear) else $error("expiry clear missed");

  property p_upper_zero;
    (spb_rd && spb_addr == tdm_pkg::OFF_CUM) |=> spb_rdata[31:24] == 8'h00;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("reserved nonzero");

  property p_hold_read;
    (spb_rd && spb_addr == tdm_pkg::OFF_CUM && spb_be == 4'h2)
      |=> spb_rdata[15:8] == $past(hold_cum_reg[7:0]);
  endproperty
  a_hold_read: assert property (p_hold_read) else $error("hold read wrong");

  property p_advance;
    (step && !cum_clr) |=> active_reg == $past(active_reg) + 24'h000001;
  endproperty
  a_advance: assert property (p_advance) else $error("active not advanced");

  property p_disable;
    !en_reg |=> active_reg == 24'h000000;
  endproperty
  a_disable: assert property (p_disable) else $error("disabled count");

  property p_limit;
    lim_hit |=> asts_reg && acnt_cap_reg == $past(acnt_reg) + 16'h0001;
  endproperty
  a_limit: assert property (p_limit) else $error("limit missed");

  c_valid: cover property (filtered_active_valid ##1 !low);
  c_expire: cover property (expire);
  c_limit: cover property (lim_hit);
endmodule : tdm_monitor

// ### src/tdm_pkg.sv
// Package for the thermal throttle duty monitor.
// Assumes a single 200 MHz mclk and an external 90 kHz enable strobe.
package tdm_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFF_CUM = 8'h00;
  localparam logic [7:0] OFF_SNAP = 8'h04;
  localparam logic [7:0] OFF_PERIOD = 8'h08;
  localparam logic [7:0] OFF_CTL = 8'h0C;
  localparam logic [7:0] OFF_ACNT = 8'h10;
  localparam logic [7:0] OFF_ALIM = 8'h14;
  // ==========================================================
  // Status/control fields
  localparam int CTL_EN = 0;
  localparam int CTL_ASTS = 1;
  localparam int CTL_PSTS = 2;
  localparam int CTL_AIE = 3;
  localparam int CTL_PIE = 4;
  // ==========================================================
  // Widths, reset values, counts
  localparam int CNT_W = 24;
  localparam int ACNT_W = 16;
  localparam logic [5:0] FILT_TICKS = 6'h28;
  localparam logic [CNT_W-1:0] CNT_RST = 24'h000000;
  localparam logic [ACNT_W-1:0] ACNT_RST = 16'h0000;
  localparam logic [ACNT_W-1:0] ACNT_MAX = 16'hFFFF;
  localparam logic [3:0] BE_WORD = 4'hF;
endpackage : tdm_pkg

// ### tb/tdm_host_model.sv
// ==========================================================
// Host processor model that drives the throttle pin low.
// Assumes the tick strobe is on mclk; the pin idles high by pull-up.
`timescale 1ns/1ps
module tdm_host_model (
  // Clock and tick
  input wire logic mclk,
  input wire logic slow_tick_enable,
  // Open-drain throttle pin
  output logic thermal_throttle_n
);
  // Released pin rests at the pull-up level
  initial thermal_throttle_n = 1'b1;

  // Low run spanning exactly n counted ticks
  task automatic low_run(input int n);
    @(posedge mclk iff slow_tick_enable);
    thermal_throttle_n <= 1'b0;
    repeat (n) @(posedge mclk iff slow_tick_enable);
    thermal_throttle_n <= 1'b1;
  endtask : low_run
endmodule : tdm_host_model

// ### tb/tdm_monitor_tb_top.sv
// ==========================================================
// Self-checking bench for the throttle duty monitor.
// Assumes a tick strobe every 8 mclk cycles to keep the run short.
`timescale 1ns/1ps
module tdm_monitor_tb_top;
  logic mclk, rstn, slow_tick_enable, thermal_throttle_n;
  logic spb_rd, spb_wr, spb_rvalid, interrupt;
  logic [7:0] spb_addr;
  logic [3:0] spb_be;
  logic [31:0] spb_wdata, spb_rdata, rd_data;
  logic [2:0] tick_cnt;
  int mismatches, n_checks, cyc;

  tdm_monitor tdm_monitor_i (.mclk(mclk), .rstn(rstn), .slow_tick_enable(slow_tick_enable),
    .thermal_throttle_n(thermal_throttle_n), .spb_rd(spb_rd), .spb_wr(spb_wr),
    .spb_addr(spb_addr), .spb_be(spb_be), .spb_wdata(spb_wdata), .spb_rdata(spb_rdata),
    .spb_rvalid(spb_rvalid), .interrupt(interrupt));
  tdm_host_model tdm_host_model_i (.mclk(mclk), .slow_tick_enable(slow_tick_enable),
    .thermal_throttle_n(thermal_throttle_n));

  // Clock
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // Tick strobe and hang limit
  always @(posedge mclk) begin
    tick_cnt <= tick_cnt + 3'h1;
    slow_tick_enable <= (tick_cnt == 3'h7);
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      mismatches++;
      finish_test;
    end
  end

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      mismatches++;
    end
  endtask : chk

  // Single-cycle register write with byte lanes
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge mclk);
    spb_wr <= 1'b1;
    spb_addr <= a;
    spb_be <= be;
    spb_wdata <= d;
    @(posedge mclk);
    spb_wr <= 1'b0;
  endtask : bus_wr

  // Register read, answer one cycle after the take
  task automatic bus_rd(input logic [7:0] a, input logic [3:0] be);
    @(posedge mclk);
    spb_rd <= 1'b1;
    spb_addr <= a;
    spb_be <= be;
    @(posedge mclk);
    spb_rd <= 1'b0;
    #1;
    chk({31'h0, spb_rvalid}, 32'h1);
    rd_data = spb_rdata;
  endtask : bus_rd

  // Counts, verdict, end of run
  task finish_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test

  // Main sequence
  initial begin
    rstn = 1'b0;
    spb_rd = 1'b0;
    spb_wr = 1'b0;
    spb_addr = 8'h00;
    spb_be = 4'hF;
    spb_wdata = 32'h0;
    slow_tick_enable = 1'b0;
    tick_cnt = 3'h0;
    mismatches = 0;
    n_checks = 0;
    cyc = 0;
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      bus_rd(8'(i * 4), 4'hF);
      chk(rd_data, 32'h0);
    end
    bus_wr(tdm_pkg::OFF_ALIM, 32'h0000FFFF, 4'hF);
    tdm_host_model_i.low_run(45);
    bus_rd(tdm_pkg::OFF_CUM, 4'hF);
    chk(rd_data, 32'h0);
    $display("test reset_disabled done");
    bus_wr(tdm_pkg::OFF_CTL, 32'h1, 4'hF);
    tdm_host_model_i.low_run(40);
    bus_rd(tdm_pkg::OFF_CUM, 4'hF);
    chk(rd_data, 32'h0);
    tdm_host_model_i.low_run(45);
    bus_rd(tdm_pkg::OFF_CUM, 4'hF);
    chk(rd_data, 32'h2D);
    $display("test filter done");
    bus_wr(tdm_pkg::OFF_PERIOD, 32'h3C, 4'hF);
    bus_wr(tdm_pkg::OFF_CTL, 32'h11, 4'hF);
    tdm_host_model_i.low_run(45);
    chk({31'h0, interrupt}, 32'h0);
    for (int k = 0; k < 2000 && interrupt !== 1'b1; k++) @(posedge mclk);
    chk({31'h0, interrupt}, 32'h1);
    bus_rd(tdm_pkg::OFF_SNAP, 4'hF);
    chk(rd_data, 32'h2D);
    bus_rd(tdm_pkg::OFF_CUM, 4'hF);
    chk(rd_data, 32'h0);
    bus_rd(tdm_pkg::OFF_CTL, 4'hF);
    chk(rd_data, 32'h15);
    bus_rd(tdm_pkg::OFF_PERIOD, 4'hF);
    chk(rd_data, 32'h3C);
    bus_wr(tdm_pkg::OFF_CTL, 32'h15, 4'hF);
    bus_wr(tdm_pkg::OFF_PERIOD, 32'h0, 4'hF);
    chk({31'h0, interrupt}, 32'h0);
    $display("test period done");
    fork
      tdm_host_model_i.low_run(300);
      begin
        repeat (100) @(posedge mclk iff slow_tick_enable);
        bus_rd(tdm_pkg::OFF_CUM, 4'h1);
      end
    join
    bus_rd(tdm_pkg::OFF_CUM, 4'h2);
    chk(rd_data & 32'h0000FF00, 32'h0);
    bus_rd(tdm_pkg::OFF_CUM, 4'hF);
    chk(rd_data, 32'h12C);
    bus_rd(tdm_pkg::OFF_CUM, 4'h1);
    bus_rd(tdm_pkg::OFF_CUM, 4'h2);
    chk(rd_data & 32'h0000FF00, 32'h100);
    $display("test byte_hold done");
    bus_wr(tdm_pkg::OFF_ALIM, 32'h14, 4'hF);
    bus_wr(tdm_pkg::OFF_CTL, 32'h9, 4'hF);
    tdm_host_model_i.low_run(25);
    chk({31'h0, interrupt}, 32'h1);
    bus_rd(tdm_pkg::OFF_ACNT, 4'hF);
    chk(rd_data, 32'h19);
    bus_rd(tdm_pkg::OFF_CTL, 4'hF);
    chk(rd_data, 32'hB);
    bus_wr(tdm_pkg::OFF_CTL, 32'hB, 4'hF);
    bus_rd(tdm_pkg::OFF_CTL, 4'hF);
    chk(rd_data, 32'h9);
    chk({31'h0, interrupt}, 32'h0);
    bus_wr(tdm_pkg::OFF_ALIM, 32'hAAAA12BB, 4'h2);
    bus_rd(tdm_pkg::OFF_ALIM, 4'hF);
    chk(rd_data, 32'h1214);
    $display("test assertion_limit done");
    // Second reset in mid-run clears every register
    @(posedge mclk);
    rstn <= 1'b0;
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      bus_rd(8'(i * 4), 4'hF);
      chk(rd_data, 32'h0);
    end
    $display("test mid_reset done");
    finish_test;
  end
endmodule : tdm_monitor_tb_top
